// ==== common/psr_pkg.sv ====
// package for the processor state and fault register block
// assumes big-endian bit numbering of the core: bit 0 is the msb of a 32-bit word
package psr_pkg;
  localparam int unsigned XLEN = 32;
  // special register numbers as seen by move-to/move-from
  localparam logic [9:0] SPR_FAULT_CAUSE = 10'h012;
  localparam logic [9:0] SPR_FAULT_ADDR  = 10'h013;
  // state register field positions, given as lsb-0 indices of bit n = 31 - n
  localparam int unsigned POS_EXC_ORDER  = 16; // bit 15
  localparam int unsigned POS_EXT_IRQ    = 15; // bit 16
  localparam int unsigned POS_USER_ONLY  = 14; // bit 17
  localparam int unsigned POS_FLOAT_AV   = 13; // bit 18
  localparam int unsigned POS_MCHK       = 12; // bit 19
  localparam int unsigned POS_FEX_A      = 11; // bit 20
  localparam int unsigned POS_STEP       = 10; // bit 21
  localparam int unsigned POS_BRANCH     = 9;  // bit 22
  localparam int unsigned POS_FEX_B      = 8;  // bit 23
  localparam int unsigned POS_VEC_HIGH   = 6;  // bit 25
  localparam int unsigned POS_RECOVER    = 1;  // bit 30
  localparam int unsigned POS_ORDER      = 0;  // bit 31
  // writable bits of the state register; everything else is reserved
  localparam logic [31:0] STATE_MASK     = 32'h0001_ff43;
  localparam logic [31:0] STATE_RESET    = 32'h0000_0000;
  localparam logic [31:0] VEC_BASE_LOW   = 32'h0000_0000;
  localparam logic [31:0] VEC_BASE_HIGH  = 32'hfff0_0000;
  localparam logic [1:0]  FEX_IGNORE     = 2'h0;
  // exception kinds reported by the core
  typedef enum logic [2:0] {
    EXC_NONE, EXC_EXT, EXC_DEC, EXC_MCHK, EXC_DATA, EXC_ALIGN, EXC_TRACE, EXC_OTHER
  } psr_exc_type;
endpackage

// ==== common/psr_wr_if.sv ====
// interface carrying one register write from the top to a storage module
// assumes a single clock; the top drives, the storage module listens
`timescale 1ns/1ps
interface psr_wr_if;
  logic        en;
  logic [31:0] data;
  logic        cap;
  logic [31:0] cap_data;
  modport src (output en, output data, output cap, output cap_data);
  modport dst (input en, input data, input cap, input cap_data);
endinterface

// ==== verilog/psr_fault_store.sv ====
// fault word store: holds a cause or address word with no reset
// assumes capture and software write never matter together; capture wins
`timescale 1ns/1ps
module psr_fault_store (
  // clock
  input  wire logic        clk,
  // update request
  psr_wr_if.dst            wr,
  // stored word
  output logic [31:0]      q
);
  // contents survive reset on purpose, so a handler can inspect them afterwards
  always_ff @(posedge clk) begin
    if (wr.cap) begin
      q <= wr.cap_data;
    end else if (wr.en) begin
      q <= wr.data;
    end
  end
endmodule

// ==== verilog/psr_state_reg.sv ====
// processor state register storage with exception entry and return
// assumes the top has already applied privilege checks on writes
`timescale 1ns/1ps
module psr_state_reg (
  // clock and synchronised reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // reset configuration word bit for the vector base
  input  wire logic        cfg_vec_high,
  // software write and exception entry
  psr_wr_if.dst            wr,
  // current value
  output logic [31:0]      q
);
  import psr_pkg::*;
  logic        cfg_seen_reg;
  logic        mchk_reg;
  logic [31:0] main_reg;
  logic [31:0] q_next;

  // machine check enable lives in its own flop so each flop has one process
  assign q = {main_reg[31:POS_MCHK+1], mchk_reg, main_reg[POS_MCHK-1:0]};

  // exception entry copies the exception byte order, software write is masked
  always_comb begin
    q_next = q;
    if (wr.cap) begin
      q_next = wr.cap_data & STATE_MASK;
      q_next[POS_ORDER] = q[POS_EXC_ORDER];
    end else if (wr.en) begin
      q_next = wr.data & STATE_MASK;
    end
  end

  // machine check enable survives reset; vector base is taken after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_seen_reg <= 1'b0;
    end else begin
      cfg_seen_reg <= 1'b1;
    end
  end

  // the strap is read one clock after release, since async reset takes only constants
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_reg <= STATE_RESET;
    end else if (!cfg_seen_reg) begin
      main_reg[POS_VEC_HIGH] <= cfg_vec_high;
    end else begin
      main_reg <= q_next;
    end
  end

  // machine check enable has no reset term: it keeps its value through reset
  always_ff @(posedge clk) begin
    if (cfg_seen_reg) begin
      mchk_reg <= q_next[POS_MCHK];
    end
  end
endmodule

// ==== verilog/psr_top.sv ====
// processor state and fault registers of the core's exception unit
// assumes the sequencer, execution units and fetch are outside; all inputs
// except NRST, which is synchronised here, are synchronous to CLOCK
// Function
// - exception copies exception byte order to normal
// - interrupt enable zero holds external and decrementer
// - user-only level permits only user instructions
// - float unavailable blocks float dispatch, not registers
// - machine checks taken only when enabled
// - step trace raises trace after clean instruction
// - step trace forces strict in-order dispatch
// - branch trace raises trace per completed branch
// - vector base bit selects table address
// - reset clears state, keeps mcheck, loads vector
// - recoverable state bit for machine checks
// - normal byte order bit selects endianness
// - float exception mode pair, zero ignores
// - data fault cause register records exception cause
// - alignment fault loads effective address
// - exception saves state then enters handler state
// - reserved bits ignore writes, read zero
`timescale 1ns/1ps
module psr_top (
  // clock and reset
  input  wire logic                CLOCK,
  input  wire logic                NRST,
  // reset configuration word bit for the vector base
  input  wire logic                CFG_VEC_HIGH,
  // special register access from the core
  input  wire logic                SPR_WR,
  input  wire logic                SPR_RD,
  input  wire logic [9:0]          SPR_NUM,
  input  wire logic [31:0]         SPR_WDATA,
  input  wire logic                STATE_WR,
  input  wire logic                STATE_RD,
  input  wire logic                RFI,
  input  wire logic [31:0]         RFI_STATE,
  output logic [31:0]              RDATA,
  output logic                     PRIV_FAULT,
  // exception entry from the sequencer
  input  wire logic                EXC_TAKE,
  input  wire psr_pkg::psr_exc_type EXC_KIND,
  input  wire logic [31:0]         EXC_CAUSE,
  input  wire logic [31:0]         EXC_ADDR,
  // pending conditions and instruction status
  input  wire logic                EXT_REQ,
  input  wire logic                DEC_REQ,
  input  wire logic                MCHK_REQ,
  input  wire logic                INSN_DONE,
  input  wire logic                INSN_EXC,
  input  wire logic                INSN_BRANCH,
  input  wire logic                INSN_FLOAT,
  input  wire logic                INSN_SUPER,
  input  wire logic                FLOAT_EXC,
  // steering outputs
  output logic [31:0]              STATE,
  output logic [31:0]              SAVED_STATE,
  output logic [31:0]              VECTOR_BASE,
  output logic                     LITTLE_ENDIAN,
  output logic                     EXT_TAKE_OK,
  output logic                     MCHK_TAKE_OK,
  output logic                     MCHK_STOP,
  output logic                     FLOAT_BLOCK,
  output logic                     SUPER_BLOCK,
  output logic                     IN_ORDER,
  output logic                     TRACE_REQ,
  output logic                     FLOAT_ASSIST,
  output logic                     RECOVERABLE
);
  import psr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoding and storage
  psr_wr_if    state_if ();
  psr_wr_if    cause_if ();
  psr_wr_if    addr_if ();
  logic [31:0] state_q;
  logic [31:0] cause_q;
  logic [31:0] addr_q;
  logic        user_only;
  logic        user_bad_write;
  logic        state_wr_ok;
  logic        handler_entry;

  // true when a move names the given special register
  function automatic logic spr_hit(input logic [9:0] num, input logic [9:0] want);
    spr_hit = (num == want);
  endfunction

  assign user_only      = state_q[POS_USER_ONLY];
  // all of these registers are supervisor-only; a user-level access is refused
  assign user_bad_write = user_only & (SPR_WR | STATE_WR | SPR_RD | STATE_RD | RFI);
  assign state_wr_ok    = ~user_only & (STATE_WR | RFI);
  assign handler_entry  = EXC_TAKE;

  // exception entry wins over software; the handler state keeps only the
  // bits that survive entry: machine check enable, vector base, exception order
  assign state_if.cap      = handler_entry;
  assign state_if.cap_data = state_q & ((32'h1 << POS_MCHK) | (32'h1 << POS_VEC_HIGH)
                             | (32'h1 << POS_EXC_ORDER));
  assign state_if.en       = state_wr_ok;
  assign state_if.data     = RFI ? RFI_STATE : SPR_WDATA;

  // cause word captured on data access and alignment faults
  assign cause_if.cap      = EXC_TAKE & ((EXC_KIND == EXC_DATA) | (EXC_KIND == EXC_ALIGN));
  assign cause_if.cap_data = EXC_CAUSE;
  assign cause_if.en       = ~user_only & SPR_WR & spr_hit(SPR_NUM, SPR_FAULT_CAUSE);
  assign cause_if.data     = SPR_WDATA;

  // faulting effective address captured on the same faults
  assign addr_if.cap       = EXC_TAKE & ((EXC_KIND == EXC_ALIGN) | (EXC_KIND == EXC_DATA));
  assign addr_if.cap_data  = EXC_ADDR;
  assign addr_if.en        = ~user_only & SPR_WR & spr_hit(SPR_NUM, SPR_FAULT_ADDR);
  assign addr_if.data      = SPR_WDATA;

  psr_state_reg u_state (
    .clk          (CLOCK),
    .rst_n        (rst_n_reg),
    .cfg_vec_high (CFG_VEC_HIGH),
    .wr           (state_if),
    .q            (state_q)
  );

  // no reset on the fault words: they hold across reset
  psr_fault_store u_cause (
    .clk (CLOCK),
    .wr  (cause_if),
    .q   (cause_q)
  );

  psr_fault_store u_addr (
    .clk (CLOCK),
    .wr  (addr_if),
    .q   (addr_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // saved state capture on exception entry
  always_ff @(posedge CLOCK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      SAVED_STATE <= STATE_RESET;
    end else if (handler_entry) begin
      SAVED_STATE <= state_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: one cycle after the request; unmapped numbers read zero
  always_ff @(posedge CLOCK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      RDATA <= 32'h0;
    end else if (user_only) begin
      RDATA <= 32'h0;
    end else if (STATE_RD) begin
      RDATA <= state_q & STATE_MASK;
    end else if (SPR_RD & spr_hit(SPR_NUM, SPR_FAULT_CAUSE)) begin
      RDATA <= cause_q;
    end else if (SPR_RD & spr_hit(SPR_NUM, SPR_FAULT_ADDR)) begin
      RDATA <= addr_q;
    end else begin
      RDATA <= 32'h0;
    end
  end

  // refused supervisor access is reported one cycle later
  always_ff @(posedge CLOCK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      PRIV_FAULT <= 1'b0;
    end else begin
      PRIV_FAULT <= user_bad_write | (user_only & INSN_SUPER);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // steering from the current state, all registered
  always_ff @(posedge CLOCK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      STATE         <= STATE_RESET;
      VECTOR_BASE   <= VEC_BASE_LOW;
      LITTLE_ENDIAN <= 1'b0;
      EXT_TAKE_OK   <= 1'b0;
      MCHK_TAKE_OK  <= 1'b0;
      MCHK_STOP     <= 1'b0;
      FLOAT_BLOCK   <= 1'b0;
      SUPER_BLOCK   <= 1'b0;
      IN_ORDER      <= 1'b0;
      FLOAT_ASSIST  <= 1'b0;
      RECOVERABLE   <= 1'b0;
    end else begin
      STATE         <= state_q;
      VECTOR_BASE   <= state_q[POS_VEC_HIGH] ? VEC_BASE_HIGH : VEC_BASE_LOW;
      LITTLE_ENDIAN <= state_q[POS_ORDER];
      // the delay is a hold-off only: requests stay pending at the source
      EXT_TAKE_OK   <= state_q[POS_EXT_IRQ] & (EXT_REQ | DEC_REQ);
      MCHK_TAKE_OK  <= state_q[POS_MCHK] & MCHK_REQ;
      // a machine check while disabled has nowhere to go; the core must stop
      MCHK_STOP     <= ~state_q[POS_MCHK] & MCHK_REQ;
      // dispatch block only; register file access stays open for moves
      FLOAT_BLOCK   <= ~state_q[POS_FLOAT_AV] & INSN_FLOAT;
      SUPER_BLOCK   <= state_q[POS_USER_ONLY];
      IN_ORDER      <= state_q[POS_STEP];
      FLOAT_ASSIST  <= FLOAT_EXC & ({state_q[POS_FEX_A], state_q[POS_FEX_B]} != FEX_IGNORE);
      RECOVERABLE   <= state_q[POS_RECOVER];
    end
  end

  // trace request: step after a clean instruction, or branch trace on any completed branch
  always_ff @(posedge CLOCK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      TRACE_REQ <= 1'b0;
    end else begin
      TRACE_REQ <= (state_q[POS_STEP] & INSN_DONE & ~INSN_EXC)
                   | (state_q[POS_BRANCH] & INSN_DONE & INSN_BRANCH);
    end
  end
endmodule

// ==== tb/psr_top_assertions.sv ====
// checker for the processor state block, watching the top module's ports only
// assumes one clock and the active-low asynchronous reset of the top
`timescale 1ns/1ps
module psr_top_assertions
  import psr_pkg::*;
(
  // clock, reset and strobes
  input wire logic        CLOCK, NRST, CFG_VEC_HIGH, STATE_WR, STATE_RD, SPR_WR, SPR_RD,
  input wire logic        RFI, EXC_TAKE, INSN_DONE, INSN_EXC, INSN_BRANCH,
  // observed outputs
  input wire logic [31:0] RDATA, STATE, SAVED_STATE, VECTOR_BASE,
  input wire logic        PRIV_FAULT, LITTLE_ENDIAN, EXT_TAKE_OK, MCHK_TAKE_OK, FLOAT_BLOCK,
  input wire logic        SUPER_BLOCK, IN_ORDER, TRACE_REQ, FLOAT_ASSIST, RECOVERABLE
);
  ////////////////////////////////////////////////////////////////////////////
  // STATE lags the stored word, so input-to-output checks wait until it settles
  logic [3:0] age_reg;
  logic       settled;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      age_reg <= 4'h0;
    end else if (STATE_WR || RFI || EXC_TAKE) begin
      age_reg <= 4'h4;
    end else if (age_reg != 4'hf) begin
      age_reg <= age_reg + 4'h1;
    end
  end
  assign settled = age_reg >= 4'h5;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////////////////////
  a_vec_base_sel: assert property (
    VECTOR_BASE == (STATE[POS_VEC_HIGH] ? VEC_BASE_HIGH : VEC_BASE_LOW))
    else $error("vector base disagrees with state");
  a_byte_order: assert property (
    LITTLE_ENDIAN == STATE[POS_ORDER]) else $error("byte order disagrees with state");
  a_recover_flag: assert property (
    RECOVERABLE == STATE[POS_RECOVER]) else $error("recoverable flag disagrees");
  a_reserved_zero: assert property (
    (STATE & ~STATE_MASK) == 32'h0) else $error("reserved state bit set");
  a_ext_gate: assert property (
    EXT_TAKE_OK |-> STATE[POS_EXT_IRQ]) else $error("external event allowed while held");
  a_mchk_gate: assert property (
    MCHK_TAKE_OK |-> STATE[POS_MCHK]) else $error("machine check allowed while off");
  a_float_gate: assert property (
    FLOAT_BLOCK |-> !STATE[POS_FLOAT_AV]) else $error("float blocked while available");
  a_super_gate: assert property (
    SUPER_BLOCK |-> STATE[POS_USER_ONLY]) else $error("supervisor blocked at top level");
  a_step_order: assert property (
    STATE[POS_STEP] |-> IN_ORDER) else $error("out of order while stepping");
  a_assist_mode: assert property (
    FLOAT_ASSIST |-> (STATE[POS_FEX_A] || STATE[POS_FEX_B])) else $error("assist in ignore mode");
  a_exc_entry: assert property (
    ((settled && EXC_TAKE) ##1 !EXC_TAKE) |=> (SAVED_STATE == $past(STATE, 2)
      && (STATE & ~32'h1) == ($past(STATE, 2) & 32'h0001_1040)
      && STATE[POS_ORDER] == STATE[POS_EXC_ORDER])) else $error("exception entry state wrong");
  a_reset_state: assert property (
    ($rose(NRST) ##1 (!(STATE_WR || RFI || EXC_TAKE))[*4]) |=> ((STATE & ~32'h0000_1040) == 32'h0
      && STATE[POS_VEC_HIGH] == CFG_VEC_HIGH)) else $error("state wrong after reset");
  a_user_refuse: assert property (
    (settled && STATE[POS_USER_ONLY] && !EXC_TAKE && (STATE_WR || STATE_RD || SPR_WR || SPR_RD))
      |=> (PRIV_FAULT && RDATA == 32'h0)) else $error("user access not refused");
  a_trace_raise: assert property (
    (settled && INSN_DONE && !INSN_EXC && (STATE[POS_STEP] || (STATE[POS_BRANCH] && INSN_BRANCH)))
      |=> TRACE_REQ) else $error("trace not raised");
  // main scenarios reached
  c_exc: cover property (EXC_TAKE ##2 SAVED_STATE != 32'h0);
  c_refuse: cover property (PRIV_FAULT);
  c_trace: cover property (TRACE_REQ);
endmodule

bind psr_top psr_top_assertions chk_u (.CLOCK, .NRST, .CFG_VEC_HIGH, .STATE_WR, .STATE_RD,
  .SPR_WR, .SPR_RD, .RFI, .EXC_TAKE, .INSN_DONE, .INSN_EXC, .INSN_BRANCH, .RDATA, .STATE,
  .SAVED_STATE, .VECTOR_BASE, .PRIV_FAULT, .LITTLE_ENDIAN, .EXT_TAKE_OK, .MCHK_TAKE_OK,
  .FLOAT_BLOCK, .SUPER_BLOCK, .IN_ORDER, .TRACE_REQ, .FLOAT_ASSIST, .RECOVERABLE);

// ==== tb/testbench.sv ====
// self-checking bench for the processor state and fault register block
// assumes the checker is bound to the top; the bench plays the core
`timescale 1ns/1ps
module testbench;
  import psr_pkg::*;
  logic CLOCK, NRST, CFG_VEC_HIGH, SPR_WR, SPR_RD, STATE_WR, STATE_RD, RFI, EXC_TAKE, EXT_REQ;
  logic DEC_REQ, MCHK_REQ, INSN_DONE, INSN_EXC, INSN_BRANCH, INSN_FLOAT, INSN_SUPER, FLOAT_EXC;
  logic PRIV_FAULT, LITTLE_ENDIAN, EXT_TAKE_OK, MCHK_TAKE_OK, MCHK_STOP, FLOAT_BLOCK;
  logic SUPER_BLOCK, IN_ORDER, TRACE_REQ, FLOAT_ASSIST, RECOVERABLE;
  logic [9:0]  SPR_NUM;
  logic [31:0] SPR_WDATA, RFI_STATE, EXC_CAUSE, EXC_ADDR, RDATA, STATE, SAVED_STATE;
  logic [31:0] VECTOR_BASE, s, cause_e, addr_e;
  psr_exc_type EXC_KIND;
  int          n_fail, n_checks;
  logic [31:0] tbl [3] = '{32'h0000_9e03, 32'h0001_2140, 32'h0};
  logic [31:0] tst [5] = '{32'h400, 32'h400, 32'h200, 32'h200, 32'h0};
  logic [2:0]  tfl [5] = '{3'h4, 3'h1, 3'h6, 3'h0, 3'h2};

  psr_top dut_u (.CLOCK, .NRST, .CFG_VEC_HIGH, .SPR_WR, .SPR_RD, .SPR_NUM, .SPR_WDATA,
    .STATE_WR, .STATE_RD, .RFI, .RFI_STATE, .RDATA, .PRIV_FAULT, .EXC_TAKE, .EXC_KIND,
    .EXC_CAUSE, .EXC_ADDR, .EXT_REQ, .DEC_REQ, .MCHK_REQ, .INSN_DONE, .INSN_EXC, .INSN_BRANCH,
    .INSN_FLOAT, .INSN_SUPER, .FLOAT_EXC, .STATE, .SAVED_STATE, .VECTOR_BASE, .LITTLE_ENDIAN,
    .EXT_TAKE_OK, .MCHK_TAKE_OK, .MCHK_STOP, .FLOAT_BLOCK, .SUPER_BLOCK, .IN_ORDER,
    .TRACE_REQ, .FLOAT_ASSIST, .RECOVERABLE);
  ////////////////////////////////////////////////////////////////////////////
  // 10 MHz core clock
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one strobe for one cycle; returns just after the edge that answers it
  task automatic op(input int k, input logic [9:0] num, input logic [31:0] d);
    @(posedge CLOCK);
    SPR_NUM <= num;
    SPR_WDATA <= d;
    RFI_STATE <= d;
    EXC_CAUSE <= d;
    EXC_ADDR <= ~d;
    EXC_KIND <= psr_exc_type'(num[2:0]);
    {INSN_BRANCH, INSN_EXC} <= d[1:0];
    case (k)
      0: STATE_WR <= 1'b1;
      1: STATE_RD <= 1'b1;
      2: SPR_WR <= 1'b1;
      3: SPR_RD <= 1'b1;
      4: RFI <= 1'b1;
      5: EXC_TAKE <= 1'b1;
      6: INSN_DONE <= 1'b1;
      default: INSN_SUPER <= 1'b1;
    endcase
    @(posedge CLOCK);
    {STATE_WR, STATE_RD, SPR_WR, SPR_RD, RFI, EXC_TAKE, INSN_DONE, INSN_SUPER} <= 8'h0;
    {INSN_BRANCH, INSN_EXC} <= 2'h0;
    #1;
  endtask
  task automatic rd(input int k, input logic [9:0] num, input logic [31:0] exp, input string w);
    op(k, num, 32'h0);
    chk(w, exp, RDATA);
  endtask
  task automatic do_reset(input logic cfg);
    @(posedge CLOCK);
    NRST <= 1'b0;
    CFG_VEC_HIGH <= cfg;
    repeat (6) @(posedge CLOCK);
    NRST <= 1'b1;
    repeat (8) @(posedge CLOCK);
  endtask
  // a hang ends the run as a mismatch
  initial begin
    repeat (5000) @(posedge CLOCK);
    n_fail++;
    $display("ERROR watchdog expired");
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_fail = 0;
    n_checks = 0;
    {NRST, CFG_VEC_HIGH, SPR_WR, SPR_RD, STATE_WR, STATE_RD, RFI, EXC_TAKE} = 8'h0;
    {INSN_DONE, INSN_EXC, INSN_BRANCH, INSN_SUPER, DEC_REQ} = 5'h0;
    {EXT_REQ, MCHK_REQ, INSN_FLOAT, FLOAT_EXC} = 4'hf;
    {SPR_NUM, SPR_WDATA, RFI_STATE, EXC_CAUSE, EXC_ADDR} = '0;
    EXC_KIND = EXC_NONE;
    do_reset(1'b0);
    // registers, reserved bits, unmapped number, second reset keeps the machine check bit
    op(0, 10'h0, 32'hffff_bfff);
    rd(1, 10'h0, STATE_MASK & 32'hffff_bfff, "state");
    op(2, SPR_FAULT_CAUSE, 32'h1234_5678);
    op(2, SPR_FAULT_ADDR, 32'h8765_4321);
    rd(3, 10'h0ff, 32'h0, "unmapped");
    op(0, 10'h0, 32'h0000_1000);
    do_reset(1'b1);
    rd(1, 10'h0, 32'h0000_1040, "reset state");
    rd(3, SPR_FAULT_CAUSE, 32'h1234_5678, "cause kept");
    rd(3, SPR_FAULT_ADDR, 32'h8765_4321, "address kept");
    op(4, 10'h0, 32'h8000_8002);
    rd(1, 10'h0, 32'h0000_8002, "restored state");
    $display("test registers done");
    // steering outputs for three state words
    for (int i = 0; i < 3; i++) begin
      op(0, 10'h0, tbl[i]);
      @(posedge CLOCK);
      EXT_REQ <= i[0];
      DEC_REQ <= ~i[0];
      @(posedge CLOCK);
      #1;
      s = tbl[i];
      chk("steering", {24'h0, s[15], s[12], ~s[12], ~s[13], s[10], s[11] | s[8], s[1], s[0]},
        {24'h0, EXT_TAKE_OK, MCHK_TAKE_OK, MCHK_STOP, FLOAT_BLOCK, IN_ORDER, FLOAT_ASSIST,
        RECOVERABLE, LITTLE_ENDIAN});
      chk("vector base", s[6] ? VEC_BASE_HIGH : VEC_BASE_LOW, VECTOR_BASE);
    end
    $display("test steering done");
    // step tracing with and without a competing exception, branch tracing with and without a branch
    for (int j = 0; j < 5; j++) begin
      op(0, 10'h0, tst[j]);
      op(6, 10'h0, {30'h0, tfl[j][1:0]});
      chk("trace", {31'h0, tfl[j][2]}, {31'h0, TRACE_REQ});
    end
    $display("test trace done");
    // every exception kind: saved word, entry state, fault capture
    cause_e = 32'h1234_5678;
    addr_e = 32'h8765_4321;
    for (int k = 1; k < 8; k++) begin
      s = k[0] ? 32'h0001_9843 : 32'h0000_0001;
      op(0, 10'h0, s);
      op(5, k[9:0], 32'ha5a5_0000 + k);
      if (k == 4 || k == 5) cause_e = 32'ha5a5_0000 + k;
      if (k == 4 || k == 5) addr_e = ~cause_e;
      rd(1, 10'h0, (s & 32'h0001_1040) | {31'h0, s[16]}, "entry state");
      chk("saved state", s, SAVED_STATE);
      rd(3, SPR_FAULT_CAUSE, cause_e, "cause");
      rd(3, SPR_FAULT_ADDR, addr_e, "fault address");
    end
    $display("test exceptions done");
    // user level refuses accesses and supervisor instructions
    op(7, 10'h0, 32'h0);
    chk("super ok", 32'h0, {30'h0, PRIV_FAULT, SUPER_BLOCK});
    op(0, 10'h0, 32'h0000_4000);
    rd(1, 10'h0, 32'h0, "user read");
    chk("user fault", 32'h1, {31'h0, PRIV_FAULT});
    op(0, 10'h0, 32'h0000_8000);
    op(7, 10'h0, 32'h0);
    chk("super blocked", 32'h3, {30'h0, PRIV_FAULT, SUPER_BLOCK});
    op(5, 10'h7, 32'h0);
    rd(1, 10'h0, 32'h0, "after user");
    $display("test user level done");
    conclude();
  end
endmodule
